// [verilog/olmi_defines.svh]
// constants for the optical link mode indicator
`ifndef OLMI_DEFINES_SVH
`define OLMI_DEFINES_SVH

// ----------------------------------------------------------------
// received level bar layout
// ----------------------------------------------------------------
`define OLMI_BAR_W 8
`define OLMI_RED_MASK 8'h03
`define OLMI_ORANGE_MASK 8'h1c
`define OLMI_GREEN_MASK 8'he0
`define OLMI_BAR_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define OLMI_CLK_MHZ 250
`define OLMI_DEBOUNCE_MS 10
`define OLMI_DEBOUNCE_CYCLES (`OLMI_DEBOUNCE_MS * 1000 * `OLMI_CLK_MHZ)
`define OLMI_DEB_CNT_W 22
`define OLMI_DEB_CNT_ZERO 22'h000000
`define OLMI_DEB_CNT_ONE 22'h000001

`endif

// [verilog/olmi_pkg.sv]
// types for the optical link mode indicator
package olmi_pkg;

	// exclusive operating modes, stepped by the selector
	typedef enum logic [1:0] {
		OLMI_MODE_AUTOMATIC = 2'b00,
		OLMI_MODE_MANUAL = 2'b01,
		OLMI_MODE_ADJUST = 2'b10,
		OLMI_MODE_LASER = 2'b11
	} olmi_mode_e;

	// link loss tracker display state
	typedef enum logic [1:0] {
		OLMI_LLT_OFF = 2'b00,
		OLMI_LLT_CLEAN = 2'b01,
		OLMI_LLT_LOST = 2'b10
	} olmi_llt_e;

endpackage

// [verilog/olmi_sync.sv]
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
module olmi_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic pin_in,
	output logic level_out
);

	logic meta_ff;
	logic level_ff;
	logic nxt_meta;
	logic nxt_level;

	// ----------------------------------------------------------------
	// synchroniser stages
	// ----------------------------------------------------------------
	// first stage feeds only the second
	always_comb begin
		nxt_meta = meta_ff;
		nxt_level = level_ff;
		if (clk_en) begin
			nxt_meta = pin_in;
			nxt_level = meta_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			level_ff <= nxt_level;
		end
	end

	assign level_out = level_ff;

endmodule

// [verilog/olmi_debounce.sv]
// debounce and press detection for the mode selector
`timescale 1ns/1ns
`include "olmi_defines.svh"
module olmi_debounce #(
	parameter logic [`OLMI_DEB_CNT_W-1:0] DEBOUNCE_CYCLES = `OLMI_DEB_CNT_W'(`OLMI_DEBOUNCE_CYCLES)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic level_in,
	output logic press_pulse
);

	logic stable_ff;
	logic press_ff;
	logic [`OLMI_DEB_CNT_W-1:0] cnt_ff;
	logic nxt_stable;
	logic nxt_press;
	logic [`OLMI_DEB_CNT_W-1:0] nxt_cnt;

	// ----------------------------------------------------------------
	// stability counter and rising-edge press
	// ----------------------------------------------------------------
	// level must differ for the full time before it is accepted
	always_comb begin
		nxt_stable = stable_ff;
		nxt_press = press_ff;
		nxt_cnt = cnt_ff;
		if (clk_en) begin
			nxt_press = 1'b0;
			if (level_in == stable_ff) begin
				nxt_cnt = `OLMI_DEB_CNT_ZERO;
			end else if (cnt_ff >= DEBOUNCE_CYCLES - `OLMI_DEB_CNT_ONE) begin
				nxt_cnt = `OLMI_DEB_CNT_ZERO;
				nxt_stable = level_in;
				nxt_press = level_in; // one pulse per actuation
			end else begin
				nxt_cnt = cnt_ff + `OLMI_DEB_CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			stable_ff <= 1'b0;
			press_ff <= 1'b0;
			cnt_ff <= `OLMI_DEB_CNT_ZERO;
		end else begin
			stable_ff <= nxt_stable;
			press_ff <= nxt_press;
			cnt_ff <= nxt_cnt;
		end
	end

	assign press_pulse = press_ff;

endmodule

// [verilog/olmi_top.sv]
// mode selection, link holding and indicator logic of the optical transceiver
`timescale 1ns/1ns
`include "olmi_defines.svh"

// Operation
// - each selector press steps to the next mode and lights its LED
// - automatic mode lights its LED green and forwards data normally
// - automatic mode holds the link while any orange segment is lit
// - manual mode lights its LED green
// - manual mode holds the link only while a green segment is lit
// - adjust mode blocks forwarding but holds link until orange and green both go dark
// - adjust mode sends own level and shows the partner's level
// - laser mode switches on the alignment laser and lights its LED
// - link loss LED dark while tracking is disabled
// - link loss LED green while no interruption since enabling
// - interruption after enabling latches link loss LED red until restart
// - master side LED green when set, dark for slave side
// - intensity warning when only red and orange segments remain
// - intensity warning drives switching output one
module olmi_top #(
	parameter logic [`OLMI_DEB_CNT_W-1:0] DEBOUNCE_CYCLES = `OLMI_DEB_CNT_W'(`OLMI_DEBOUNCE_CYCLES)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic mode_select_pin,
	input wire logic link_loss_enable_pin,
	input wire logic master_side_setting_pin,
	input wire logic [`OLMI_BAR_W-1:0] local_level,
	input wire logic [`OLMI_BAR_W-1:0] remote_level,
	input wire logic remote_level_valid,
	output logic automatic_mode_led,
	output logic manual_adjust_mode_led,
	output logic remote_level_adjust_mode_led,
	output logic alignment_laser_mode_led,
	output logic alignment_laser_on,
	output logic link_loss_tracker_led_green,
	output logic link_loss_tracker_led_red,
	output logic master_side_setting_led,
	output logic optical_link_active,
	output logic data_forward_enable,
	output logic [`OLMI_BAR_W-1:0] received_level_bar,
	output logic [`OLMI_BAR_W-1:0] level_to_remote,
	output logic level_to_remote_valid,
	output logic switching_output_one
);

	// ----------------------------------------------------------------
	// pin synchronisers and selector debounce
	// ----------------------------------------------------------------
	logic mode_sel_sync;
	logic llt_en_sync;
	logic master_sync;
	logic mode_press;

	olmi_sync u_sync_mode (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.pin_in(mode_select_pin),
		.level_out(mode_sel_sync)
	);

	olmi_sync u_sync_llt (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.pin_in(link_loss_enable_pin),
		.level_out(llt_en_sync)
	);

	olmi_sync u_sync_master (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.pin_in(master_side_setting_pin),
		.level_out(master_sync)
	);

	olmi_debounce #(
		.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
	) u_debounce (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.level_in(mode_sel_sync),
		.press_pulse(mode_press)
	);

	// ----------------------------------------------------------------
	// level bar decode
	// ----------------------------------------------------------------
	logic any_orange;
	logic any_green;

	// segments of the own measured level
	assign any_orange = |(local_level & `OLMI_ORANGE_MASK);
	assign any_green = |(local_level & `OLMI_GREEN_MASK);

	// ----------------------------------------------------------------
	// operating mode state
	// ----------------------------------------------------------------
	olmi_pkg::olmi_mode_e mode_ff;
	olmi_pkg::olmi_mode_e nxt_mode;

	// selector press advances through the exclusive modes
	always_comb begin
		nxt_mode = mode_ff;
		if (clk_en && mode_press) begin
			case (mode_ff)
				olmi_pkg::OLMI_MODE_AUTOMATIC: nxt_mode = olmi_pkg::OLMI_MODE_MANUAL;
				olmi_pkg::OLMI_MODE_MANUAL: nxt_mode = olmi_pkg::OLMI_MODE_ADJUST;
				olmi_pkg::OLMI_MODE_ADJUST: nxt_mode = olmi_pkg::OLMI_MODE_LASER;
				olmi_pkg::OLMI_MODE_LASER: nxt_mode = olmi_pkg::OLMI_MODE_AUTOMATIC;
				default: nxt_mode = olmi_pkg::OLMI_MODE_AUTOMATIC;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode_ff <= olmi_pkg::OLMI_MODE_AUTOMATIC;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// ----------------------------------------------------------------
	// optical link hold
	// ----------------------------------------------------------------
	logic link_ff;
	logic nxt_link;

	// link comes up on a green segment, drop threshold depends on mode
	always_comb begin
		nxt_link = link_ff;
		if (clk_en) begin
			if (!link_ff) begin
				nxt_link = any_green;
			end else begin
				case (nxt_mode)
					olmi_pkg::OLMI_MODE_MANUAL: begin
						nxt_link = any_green;
					end
					default: begin
						nxt_link = any_orange | any_green;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			link_ff <= 1'b0;
		end else begin
			link_ff <= nxt_link;
		end
	end

	// ----------------------------------------------------------------
	// link loss tracker
	// ----------------------------------------------------------------
	olmi_pkg::olmi_llt_e llt_ff;
	olmi_pkg::olmi_llt_e nxt_llt;

	// enabling restarts tracking, any drop of the link latches loss
	always_comb begin
		nxt_llt = llt_ff;
		if (clk_en) begin
			case (llt_ff)
				olmi_pkg::OLMI_LLT_OFF: begin
					if (llt_en_sync) begin
						nxt_llt = olmi_pkg::OLMI_LLT_CLEAN;
					end
				end
				olmi_pkg::OLMI_LLT_CLEAN: begin
					if (!llt_en_sync) begin
						nxt_llt = olmi_pkg::OLMI_LLT_OFF;
					end else if (link_ff && !nxt_link) begin
						nxt_llt = olmi_pkg::OLMI_LLT_LOST;
					end
				end
				olmi_pkg::OLMI_LLT_LOST: begin
					if (!llt_en_sync) begin
						nxt_llt = olmi_pkg::OLMI_LLT_OFF;
					end
				end
				default: begin
					nxt_llt = olmi_pkg::OLMI_LLT_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			llt_ff <= olmi_pkg::OLMI_LLT_OFF;
		end else begin
			llt_ff <= nxt_llt;
		end
	end

	// ----------------------------------------------------------------
	// registered indicator and data outputs
	// ----------------------------------------------------------------
	logic aut_led_ff;
	logic man_led_ff;
	logic adj_led_ff;
	logic las_led_ff;
	logic laser_on_ff;
	logic llt_green_ff;
	logic llt_red_ff;
	logic master_led_ff;
	logic fwd_ff;
	logic warn_ff;
	logic tx_valid_ff;
	logic [`OLMI_BAR_W-1:0] bar_ff;
	logic [`OLMI_BAR_W-1:0] tx_level_ff;
	logic nxt_aut_led;
	logic nxt_man_led;
	logic nxt_adj_led;
	logic nxt_las_led;
	logic nxt_laser_on;
	logic nxt_llt_green;
	logic nxt_llt_red;
	logic nxt_master_led;
	logic nxt_fwd;
	logic nxt_warn;
	logic nxt_tx_valid;
	logic [`OLMI_BAR_W-1:0] nxt_bar;
	logic [`OLMI_BAR_W-1:0] nxt_tx_level;

	// outputs follow the next state so LEDs match the mode register
	always_comb begin
		nxt_aut_led = aut_led_ff;
		nxt_man_led = man_led_ff;
		nxt_adj_led = adj_led_ff;
		nxt_las_led = las_led_ff;
		nxt_laser_on = laser_on_ff;
		nxt_llt_green = llt_green_ff;
		nxt_llt_red = llt_red_ff;
		nxt_master_led = master_led_ff;
		nxt_fwd = fwd_ff;
		nxt_warn = warn_ff;
		nxt_tx_valid = tx_valid_ff;
		nxt_bar = bar_ff;
		nxt_tx_level = tx_level_ff;
		if (clk_en) begin
			nxt_aut_led = (nxt_mode == olmi_pkg::OLMI_MODE_AUTOMATIC);
			nxt_man_led = (nxt_mode == olmi_pkg::OLMI_MODE_MANUAL);
			nxt_adj_led = (nxt_mode == olmi_pkg::OLMI_MODE_ADJUST);
			nxt_las_led = (nxt_mode == olmi_pkg::OLMI_MODE_LASER);
			nxt_laser_on = (nxt_mode == olmi_pkg::OLMI_MODE_LASER);
			nxt_llt_green = (nxt_llt == olmi_pkg::OLMI_LLT_CLEAN);
			nxt_llt_red = (nxt_llt == olmi_pkg::OLMI_LLT_LOST);
			nxt_master_led = master_sync;
			nxt_fwd = nxt_link && (nxt_mode != olmi_pkg::OLMI_MODE_ADJUST);
			nxt_warn = !any_green;
			nxt_tx_level = local_level;
			nxt_tx_valid = (nxt_mode == olmi_pkg::OLMI_MODE_ADJUST);
			if (nxt_mode == olmi_pkg::OLMI_MODE_ADJUST) begin
				if (remote_level_valid) begin
					nxt_bar = remote_level;
				end
			end else begin
				nxt_bar = local_level;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			aut_led_ff <= 1'b1;
			man_led_ff <= 1'b0;
			adj_led_ff <= 1'b0;
			las_led_ff <= 1'b0;
			laser_on_ff <= 1'b0;
			llt_green_ff <= 1'b0;
			llt_red_ff <= 1'b0;
			master_led_ff <= 1'b0;
			fwd_ff <= 1'b0;
			warn_ff <= 1'b1;
			tx_valid_ff <= 1'b0;
			bar_ff <= `OLMI_BAR_RESET;
			tx_level_ff <= `OLMI_BAR_RESET;
		end else begin
			aut_led_ff <= nxt_aut_led;
			man_led_ff <= nxt_man_led;
			adj_led_ff <= nxt_adj_led;
			las_led_ff <= nxt_las_led;
			laser_on_ff <= nxt_laser_on;
			llt_green_ff <= nxt_llt_green;
			llt_red_ff <= nxt_llt_red;
			master_led_ff <= nxt_master_led;
			fwd_ff <= nxt_fwd;
			warn_ff <= nxt_warn;
			tx_valid_ff <= nxt_tx_valid;
			bar_ff <= nxt_bar;
			tx_level_ff <= nxt_tx_level;
		end
	end

	// ----------------------------------------------------------------
	// port drive
	// ----------------------------------------------------------------
	assign automatic_mode_led = aut_led_ff;
	assign manual_adjust_mode_led = man_led_ff;
	assign remote_level_adjust_mode_led = adj_led_ff;
	assign alignment_laser_mode_led = las_led_ff;
	assign alignment_laser_on = laser_on_ff;
	assign link_loss_tracker_led_green = llt_green_ff;
	assign link_loss_tracker_led_red = llt_red_ff;
	assign master_side_setting_led = master_led_ff;
	assign optical_link_active = link_ff;
	assign data_forward_enable = fwd_ff;
	assign received_level_bar = bar_ff;
	assign level_to_remote = tx_level_ff;
	assign level_to_remote_valid = tx_valid_ff;
	assign switching_output_one = warn_ff;

endmodule

// [bench/olmi_partner.sv]
// model of the opposing transceiver on the other frequency
`timescale 1ns/1ns
module olmi_partner (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] own_level,
	input wire logic level_to_remote_valid,
	output logic [7:0] remote_level,
	output logic remote_level_valid
);
	// follows the device into adjust mode, else the level lines toggle
	// mirror own level
	always_ff @(posedge clk) begin
		if (!resetn) begin
			remote_level <= 8'h00;
			remote_level_valid <= 1'b0;
		end else if (level_to_remote_valid) begin
			remote_level <= own_level;
			remote_level_valid <= 1'b1;
		end else begin
			remote_level <= ~remote_level; // released lines carry no stale value
			remote_level_valid <= 1'b0;
		end
	end
endmodule

// [bench/olmi_checker.sv]
// port assertions for the optical link mode indicator
`timescale 1ns/1ns
`include "olmi_defines.svh"
module olmi_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic master_side_setting_pin,
	input wire logic [`OLMI_BAR_W-1:0] local_level,
	input wire logic [`OLMI_BAR_W-1:0] remote_level,
	input wire logic remote_level_valid,
	input wire logic automatic_mode_led,
	input wire logic manual_adjust_mode_led,
	input wire logic remote_level_adjust_mode_led,
	input wire logic alignment_laser_mode_led,
	input wire logic alignment_laser_on,
	input wire logic link_loss_tracker_led_green,
	input wire logic link_loss_tracker_led_red,
	input wire logic master_side_setting_led,
	input wire logic optical_link_active,
	input wire logic data_forward_enable,
	input wire logic [`OLMI_BAR_W-1:0] received_level_bar,
	input wire logic [`OLMI_BAR_W-1:0] level_to_remote,
	input wire logic switching_output_one
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// bar groups at the input
	logic has_green;
	logic has_hold;
	assign has_green = |(local_level & `OLMI_GREEN_MASK);
	assign has_hold = |(local_level & (`OLMI_GREEN_MASK | `OLMI_ORANGE_MASK));
	chk_mode_onehot: assert property (
		$onehot({automatic_mode_led, manual_adjust_mode_led,
		remote_level_adjust_mode_led, alignment_laser_mode_led}))
		else $error("mode leds not one hot");
	chk_laser_follows: assert property (
		alignment_laser_on == alignment_laser_mode_led) else $error("laser mismatch");
	chk_adjust_blocks: assert property (
		remote_level_adjust_mode_led [*2] |-> !data_forward_enable)
		else $error("forwarding in adjust mode");
	chk_forward_link: assert property (
		data_forward_enable |-> optical_link_active) else $error("forward without link");
	// a frozen clock enable holds the outputs, so only enabled cycles are compared
	chk_level_sent: assert property (
		$past(resetn) && $past(clk_en) |-> level_to_remote == $past(local_level))
		else $error("sent level wrong");
	chk_warning_out: assert property (
		$past(resetn) && $past(clk_en) |-> switching_output_one == !$past(has_green))
		else $error("warning wrong");
	// the mode must still be the same one when the link result shows
	chk_manual_drop: assert property (
		clk_en && manual_adjust_mode_led && !has_green ##1 manual_adjust_mode_led
		|-> !optical_link_active) else $error("manual link kept");
	chk_dark_drop: assert property (
		clk_en && !has_hold |=> !optical_link_active) else $error("link kept on dark bar");
	chk_auto_hold: assert property (
		automatic_mode_led && optical_link_active && has_hold ##1 automatic_mode_led
		|-> optical_link_active) else $error("auto link dropped");
	// tracker state and link fall on the same edge
	chk_loss_red: assert property (
		$fell(optical_link_active) && $past(link_loss_tracker_led_green)
		|-> link_loss_tracker_led_red) else $error("loss not latched");
	chk_tracker_excl: assert property (
		!(link_loss_tracker_led_green && link_loss_tracker_led_red)) else $error("both tracker leds");
	chk_master_led: assert property (
		$rose(master_side_setting_pin) |-> ##[1:5] master_side_setting_led)
		else $error("master led late");
	chk_remote_bar: assert property (
		clk_en && remote_level_adjust_mode_led && remote_level_valid
		##1 remote_level_adjust_mode_led |-> received_level_bar == $past(remote_level))
		else $error("remote bar wrong");
	// main scenarios reached
	cover property (remote_level_adjust_mode_led && remote_level_valid);
	cover property ($rose(link_loss_tracker_led_red));
	cover property ($rose(alignment_laser_on));
endmodule
bind olmi_top olmi_checker i_olmi_checker (
	.clk(clk), .resetn(resetn), .clk_en(clk_en),
	.master_side_setting_pin(master_side_setting_pin),
	.local_level(local_level), .remote_level(remote_level),
	.remote_level_valid(remote_level_valid), .automatic_mode_led(automatic_mode_led),
	.manual_adjust_mode_led(manual_adjust_mode_led),
	.remote_level_adjust_mode_led(remote_level_adjust_mode_led),
	.alignment_laser_mode_led(alignment_laser_mode_led), .alignment_laser_on(alignment_laser_on),
	.link_loss_tracker_led_green(link_loss_tracker_led_green),
	.link_loss_tracker_led_red(link_loss_tracker_led_red),
	.master_side_setting_led(master_side_setting_led), .optical_link_active(optical_link_active),
	.data_forward_enable(data_forward_enable), .received_level_bar(received_level_bar),
	.level_to_remote(level_to_remote), .switching_output_one(switching_output_one)
);

// [bench/olmi_top_tb_top.sv]
// self-checking bench for the optical link mode indicator
`timescale 1ns/1ns
module olmi_top_tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic mode_select_pin = 1'b0;
	logic link_loss_enable_pin = 1'b0;
	logic master_side_setting_pin = 1'b0;
	logic [7:0] local_level = 8'h00;
	logic [7:0] partner_level = 8'h5a;
	logic [7:0] remote_level;
	logic remote_level_valid;
	logic clk_en = 1'b1;
	wire [3:0] mode_leds;
	wire [7:0] status;
	logic [7:0] bar;
	logic [7:0] to_remote;
	int error_cnt = 0;
	int num_checks = 0;
	// rows: level, then expected link and warning
	logic [9:0] rows [5] = '{{8'h20, 2'b10}, {8'h04, 2'b11}, {8'h01, 2'b01},
		{8'h04, 2'b01}, {8'he0, 2'b10}};
	logic [7:0] exp_mode [4] = '{8'h04, 8'h02, 8'h01, 8'h08};
	logic [7:0] exp_stat [4] = '{8'hc0, 8'h81, 8'hd0, 8'hc0};
	// 250 MHz clock
	always #2 clk = ~clk;
	olmi_top #(.DEBOUNCE_CYCLES(22'h000004)) i_olmi_top (
		.clk(clk), .resetn(resetn), .clk_en(clk_en), .mode_select_pin(mode_select_pin),
		.link_loss_enable_pin(link_loss_enable_pin),
		.master_side_setting_pin(master_side_setting_pin), .local_level(local_level),
		.remote_level(remote_level), .remote_level_valid(remote_level_valid),
		.automatic_mode_led(mode_leds[3]), .manual_adjust_mode_led(mode_leds[2]),
		.remote_level_adjust_mode_led(mode_leds[1]), .alignment_laser_mode_led(mode_leds[0]),
		.alignment_laser_on(status[4]), .link_loss_tracker_led_green(status[3]),
		.link_loss_tracker_led_red(status[2]), .master_side_setting_led(status[1]),
		.optical_link_active(status[7]), .data_forward_enable(status[6]),
		.received_level_bar(bar), .level_to_remote(to_remote),
		.level_to_remote_valid(status[0]), .switching_output_one(status[5])
	);
	olmi_partner i_olmi_partner (
		.clk(clk), .resetn(resetn), .own_level(partner_level),
		.level_to_remote_valid(status[0]), .remote_level(remote_level),
		.remote_level_valid(remote_level_valid)
	);
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input int n);
		@(posedge clk);
		mode_select_pin <= 1'b1;
		wait_cyc(n);
		@(posedge clk);
		mode_select_pin <= 1'b0;
		wait_cyc(12);
	endtask
	task automatic set_level(input logic [7:0] v);
		@(posedge clk);
		local_level <= v;
		wait_cyc(2);
	endtask
	task automatic set_pins(input logic en, input logic master_side_setting);
		@(posedge clk);
		link_loss_enable_pin <= en;
		master_side_setting_pin <= master_side_setting;
		wait_cyc(6);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		#1;
		check("mode leds", {4'h0, mode_leds}, 8'h08);
		check("status", status, 8'h20);
		foreach (rows[i]) begin
			set_level(rows[i][9:2]);
			check("bar", bar, rows[i][9:2]);
			check("sent level", to_remote, rows[i][9:2]);
			check("status", status, {rows[i][1], rows[i][1:0], 5'h00});
		end
		$display("test levels done");
		pulse(2);
		check("mode leds", {4'h0, mode_leds}, 8'h08);
		for (int m = 0; m < 4; m++) begin
			pulse(12);
			check("mode leds", {4'h0, mode_leds}, exp_mode[m]);
			check("status", status, exp_stat[m]);
			if (m == 1) check("bar", bar, partner_level);
		end
		$display("test modes done");
		pulse(12);
		set_level(8'h04);
		check("status", status, 8'h20);
		set_level(8'he0);
		pulse(12);
		set_level(8'h04);
		check("status", status, 8'ha1);
		set_level(8'he0);
		pulse(12);
		pulse(12);
		$display("test holds done");
		set_pins(1'b1, 1'b1);
		check("status", status, 8'hca);
		set_level(8'h01);
		wait_cyc(2);
		check("status", status, 8'h26);
		set_level(8'he0);
		check("status", status, 8'hc6);
		set_pins(1'b0, 1'b0);
		check("status", status, 8'hc0);
		set_pins(1'b1, 1'b0);
		check("status", status, 8'hc8);
		$display("test tracker done");
		// low clock enable freezes every output, the drop lands once it returns
		@(posedge clk);
		clk_en <= 1'b0;
		local_level <= 8'h01;
		wait_cyc(4);
		check("status", status, 8'hc8);
		check("bar", bar, 8'he0);
		@(posedge clk);
		clk_en <= 1'b1;
		wait_cyc(2);
		check("status", status, 8'h24);
		check("bar", bar, 8'h01);
		$display("test freeze done");
		// leave automatic mode so that reset has something to undo
		pulse(12);
		@(posedge clk);
		resetn <= 1'b0;
		wait_cyc(2);
		check("mode leds", {4'h0, mode_leds}, 8'h08);
		check("status", status, 8'h20);
		@(posedge clk);
		resetn <= 1'b1;
		set_level(8'he0);
		wait_cyc(4);
		check("mode leds", {4'h0, mode_leds}, 8'h08);
		check("status", status, 8'hc8);
		$display("test reset done");
		final_report();
	end
	// watchdog well past the expected run of about 340 cycles
	initial begin
		#20000;
		error_cnt++;
		final_report();
	end
endmodule
